// ===== hw/dcsc_defines.vh
// Constants for the debug console subroutine control block
`ifndef DCSC_DEFINES_VH
`define DCSC_DEFINES_VH
// Register byte offsets
`define DCSC_OFS_CMD      8'h00
`define DCSC_OFS_STATUS   8'h04
`define DCSC_OFS_BPCOND   8'h08
`define DCSC_OFS_BPMASK   8'h0C
`define DCSC_OFS_BPACT    8'h10
`define DCSC_OFS_OVLORG   8'h14
`define DCSC_OFS_TRACE    8'h18
`define DCSC_OFS_ROMPTR   8'h1C
`define DCSC_OFS_ROMDATA  8'h20
`define DCSC_OFS_SHADOW   8'h24
// Panel command codes, written to CMD[3:0]
`define DCSC_K_HALT       4'h0
`define DCSC_K_RUNDISP    4'h1
`define DCSC_K_RUNRT      4'h2
`define DCSC_K_BPEN       4'h3
`define DCSC_K_BPDIS      4'h4
`define DCSC_K_TRALL      4'h5
`define DCSC_K_TRBP       4'h6
`define DCSC_K_TRDISP     4'h7
`define DCSC_K_TRNEXT     4'h8
`define DCSC_K_TRPREV     4'h9
`define DCSC_K_CPURST     4'hA
`define DCSC_K_SUBR       4'hB
`define DCSC_K_FINISH     4'hC
`define DCSC_K_OVLEN      4'hD
`define DCSC_K_OVLDIS     4'hE
`define DCSC_K_TROFF      4'hF
// Trace modes
`define DCSC_TR_OFF       2'h0
`define DCSC_TR_ALL       2'h1
`define DCSC_TR_BP        2'h2
// Breakpoint actions
`define DCSC_ACT_HALT     2'h0
`define DCSC_ACT_COUNT    2'h1
// Subroutine ROM layout
`define DCSC_VEC_BASE     11'h000
`define DCSC_CFG_BASE     11'h020
`define DCSC_CFG_SIZE     11'h00C
`define DCSC_SHADOW_TOP   11'h080
`define DCSC_CFG_SUBRS    4'h8
`define DCSC_LAST_BYTE    4'hD
// Config byte 0 flag bits
`define DCSC_CF_RST       0
`define DCSC_CF_TRLO      1
`define DCSC_CF_TRHI      2
`define DCSC_CF_BPEN      3
`define DCSC_CF_OVLEN     4
// Target reset pulse
`define DCSC_RST_NS       1000
`define DCSC_CLK_NS       10
`endif

// ===== hw/dcsc_top.v
// Debug console control: run-state gating, trace, breakpoint, subroutine launch
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "dcsc_defines.vh"
module dcsc_top #(
   parameter TRACE_AW = 8,
   parameter ROM_AW   = 11
) (
   input  wire                ref_clk,
   input  wire                sys_rst,
   input  wire                console_reset_key,
   input  wire                psel,
   input  wire                penable,
   input  wire                pwrite,
   input  wire [7:0]          paddr,
   input  wire [31:0]         pwdata,
   output reg  [31:0]         prdata_q,
   output reg                 pready_q,
   output reg                 pslverr_q,
   input  wire                tgt_cyc_valid,
   input  wire [15:0]         tgt_addr,
   input  wire [7:0]          tgt_data,
   input  wire [7:0]          tgt_stat,
   input  wire [7:0]          tgt_pins,
   input  wire                tgt_lost,
   input  wire                ovl_size_2k,
   input  wire [7:0]          rom_rdata,
   output reg  [ROM_AW-1:0]   rom_addr_q,
   output reg                 tgt_reset_q,
   output reg                 tgt_halt_q,
   output reg                 steal_ok_q,
   output reg                 sys_err_q,
   output reg                 tgt_pc_load_q,
   output reg  [15:0]         tgt_pc_q,
   output reg                 tgt_int_disable_q,
   output reg                 bp_enable_q,
   output reg                 ovl_enable_q,
   output reg  [15:0]         ovl_origin_q
);
   localparam RST_CYC = (`DCSC_RST_NS + `DCSC_CLK_NS - 1) / `DCSC_CLK_NS;
   localparam [7:0] RST_CYC8 = RST_CYC[7:0];
   // One-hot run states
   localparam [4:0] S_HALT = 5'h01;
   localparam [4:0] S_DISP = 5'h02;
   localparam [4:0] S_RT   = 5'h04;
   localparam [4:0] S_ERR  = 5'h08;
   localparam [4:0] S_LNCH = 5'h10;

   // Console reset acts like sys_rst on every register; the trace and shadow memories are not cleared
   wire clr = sys_rst | console_reset_key;

   reg [4:0]          state_q;
   reg [31:0]         bp_cond_q;
   reg [31:0]         bp_mask_q;
   reg [1:0]          bp_act_q;
   reg [7:0]          pass_cnt_q;
   reg [3:0]          subr_q;
   reg                subr_armed_q;
   reg [1:0]          trace_mode_q;
   reg [TRACE_AW-1:0] tr_wptr_q;
   reg [TRACE_AW-1:0] tr_dptr_q;
   reg [ROM_AW-1:0]   rom_ptr_q;
   reg [7:0]          rom_byte_q;
   reg                err_q;
   reg [7:0]          rst_cnt_q;
   reg [3:0]          lb_q;
   reg                lphase_q;
   reg [7:0]          cfg0_q;
   reg [31:0]         trace_mem [0:(1<<TRACE_AW)-1];
   reg [7:0]          shadow_mem [0:127];

   // Masked breakpoint compare; mask zero bits are don't-care
   function bp_hit;
      input [31:0] cyc;
      input [31:0] cond;
      input [31:0] mask;
      begin
         bp_hit = (((cyc ^ cond) & mask) == 32'h0000_0000);
      end
   endfunction

   // Round origin down to the overlay block boundary
   function [15:0] ovl_round;
      input [15:0] org;
      input        big;
      begin
         ovl_round = big ? (org & 16'hF800) : (org & 16'hFC00);
      end
   endfunction

   // Launch byte address: two vector bytes then twelve config bytes
   function [ROM_AW-1:0] lnch_addr;
      input [3:0] subr;
      input [3:0] idx;
      reg   [10:0] a;
      begin
         a = 11'h000;
         if (idx < 4'h2)
            a = `DCSC_VEC_BASE + {6'h00, subr, 1'b0} + {10'h000, idx[0]};
         else
            a = `DCSC_CFG_BASE + ({7'h00, subr} * `DCSC_CFG_SIZE) + {7'h00, idx - 4'h2};
         lnch_addr = a[ROM_AW-1:0];
      end
   endfunction

   // Which commands each run state accepts
   function cmd_ok;
      input [4:0] st;
      input [3:0] k;
      begin
         case (st)
            S_HALT:  cmd_ok = (k != `DCSC_K_CPURST) || 1'b1;
            S_DISP:  cmd_ok = (k != `DCSC_K_SUBR);
            // Real time: nothing that would steal target cycles
            S_RT:    cmd_ok = (k == `DCSC_K_HALT) || (k == `DCSC_K_RUNDISP) || (k == `DCSC_K_TRALL) ||
                              (k == `DCSC_K_TRBP) || (k == `DCSC_K_TRDISP) || (k == `DCSC_K_TRNEXT) ||
                              (k == `DCSC_K_TRPREV) || (k == `DCSC_K_TROFF) || (k == `DCSC_K_CPURST) ||
                              (k == `DCSC_K_FINISH);
            S_ERR:   cmd_ok = (k == `DCSC_K_BPDIS) || (k == `DCSC_K_TRALL) || (k == `DCSC_K_TRBP) ||
                              (k == `DCSC_K_TRDISP) || (k == `DCSC_K_TRNEXT) || (k == `DCSC_K_TRPREV);
            default: cmd_ok = 1'b0;
         endcase
      end
   endfunction

   // APB decode
   wire        setup   = psel & ~penable;
   wire        acc     = psel & penable & pready_q;
   wire        wr_acc  = acc & pwrite & ~pslverr_q;
   wire [3:0]  key     = pwdata[3:0];
   wire        locked  = (state_q == S_RT) || (state_q == S_ERR) || (state_q == S_LNCH);
   wire        is_cmd  = (paddr == `DCSC_OFS_CMD);
   wire        is_lock = (paddr == `DCSC_OFS_BPCOND) || (paddr == `DCSC_OFS_BPMASK) ||
                         (paddr == `DCSC_OFS_BPACT) || (paddr == `DCSC_OFS_OVLORG);
   wire        mapped  = (paddr[1:0] == 2'b00) && (paddr <= `DCSC_OFS_SHADOW);
   wire        cmd_go  = wr_acc & is_cmd;
   wire [31:0] cyc_word = {tgt_addr, tgt_data, tgt_stat};
   wire        hit     = bp_hit(cyc_word, bp_cond_q, bp_mask_q);
   wire [TRACE_AW-1:0] tr_last = tr_wptr_q - {{(TRACE_AW-1){1'b0}}, 1'b1};
   // Byte seen by the launch at the current ROM address
   wire [7:0]  lnch_byte = rom_byte_q_src(rom_addr_q, rom_rdata);

   // Refusal decided at setup so the access phase answers at once
   wire refuse = ~mapped || (pwrite && is_lock && locked) ||
                 (pwrite && is_cmd && !cmd_ok(state_q, key)) ||
                 (pwrite && is_cmd && key == `DCSC_K_FINISH && state_q == S_HALT && !subr_armed_q);

   // Register read mux
   reg [31:0] rd_mux;
   always @*
   begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `DCSC_OFS_STATUS:  rd_mux = {8'h00, tgt_pins, 1'b0, err_q, trace_mode_q, ovl_enable_q, bp_enable_q,
                                     subr_armed_q, tgt_reset_q, 3'h0, state_q};
         `DCSC_OFS_BPCOND:  rd_mux = bp_cond_q;
         `DCSC_OFS_BPMASK:  rd_mux = bp_mask_q;
         `DCSC_OFS_BPACT:   rd_mux = {12'h000, subr_q, pass_cnt_q, 6'h00, bp_act_q};
         `DCSC_OFS_OVLORG:  rd_mux = {16'h0000, ovl_origin_q};
         `DCSC_OFS_TRACE:   rd_mux = trace_mem[tr_dptr_q];
         `DCSC_OFS_ROMPTR:  rd_mux = {{(32-ROM_AW){1'b0}}, rom_ptr_q};
         `DCSC_OFS_ROMDATA: rd_mux = {24'h000000, rom_byte_q};
         default:           rd_mux = 32'h0000_0000;
      endcase
   end

   // APB slave handshake: ready in the first access cycle
   always @(posedge ref_clk)
   begin
      if (clr)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= setup;
         if (setup)
         begin
            pslverr_q <= refuse;
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
         end
         else if (acc)
         begin
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
         end
      end
   end

   // Trace store; circular, oldest entries overwritten
   always @(posedge ref_clk)
   begin
      if (tgt_cyc_valid && ((trace_mode_q == `DCSC_TR_ALL) || ((trace_mode_q == `DCSC_TR_BP) && hit)))
         trace_mem[tr_wptr_q] <= cyc_word;
   end

   // Shadow RAM over the vector and config region, loaded by software
   always @(posedge ref_clk)
   begin
      if (wr_acc && paddr == `DCSC_OFS_SHADOW)
         shadow_mem[pwdata[14:8]] <= pwdata[7:0];
   end

   // Main control: run state, keys, setup registers, launch sequence
   always @(posedge ref_clk)
   begin
      if (clr)
      begin
         state_q           <= S_HALT;
         bp_cond_q         <= 32'h0000_0000;
         bp_mask_q         <= 32'h0000_0000;
         bp_act_q          <= `DCSC_ACT_HALT;
         pass_cnt_q        <= 8'h00;
         subr_q            <= 4'h0;
         subr_armed_q      <= 1'b0;
         trace_mode_q      <= `DCSC_TR_OFF;
         tr_wptr_q         <= {TRACE_AW{1'b0}};
         tr_dptr_q         <= {TRACE_AW{1'b0}};
         rom_ptr_q         <= {ROM_AW{1'b0}};
         rom_byte_q        <= 8'h00;
         rom_addr_q        <= {ROM_AW{1'b0}};
         err_q             <= 1'b0;
         rst_cnt_q         <= RST_CYC8;
         tgt_reset_q       <= 1'b1;
         tgt_halt_q        <= 1'b1;
         steal_ok_q        <= 1'b0;
         sys_err_q         <= 1'b0;
         tgt_pc_load_q     <= 1'b0;
         tgt_pc_q          <= 16'h0000;
         tgt_int_disable_q <= 1'b0;
         bp_enable_q       <= 1'b0;
         ovl_enable_q      <= 1'b0;
         ovl_origin_q      <= 16'h0000;
         lb_q              <= 4'h0;
         lphase_q          <= 1'b0;
         cfg0_q            <= 8'h00;
      end
      else
      begin
         tgt_pc_load_q     <= 1'b0;
         tgt_int_disable_q <= 1'b0;
         // Target reset pulse timer
         if (rst_cnt_q != 8'h00)
            rst_cnt_q <= rst_cnt_q - 8'h01;
         tgt_reset_q <= (rst_cnt_q > 8'h01);
         // Trace write pointer advances with each recorded cycle
         if (tgt_cyc_valid && ((trace_mode_q == `DCSC_TR_ALL) || ((trace_mode_q == `DCSC_TR_BP) && hit)))
            tr_wptr_q <= tr_wptr_q + {{(TRACE_AW-1){1'b0}}, 1'b1};
         // ROM browse latch, idle when the launch owns the ROM port
         if (state_q != S_LNCH)
         begin
            rom_addr_q <= rom_ptr_q;
            rom_byte_q <= (rom_addr_q < `DCSC_SHADOW_TOP) ? shadow_mem[rom_addr_q[6:0]] : rom_rdata;
         end
         // Setup register writes, already screened by the lock
         if (wr_acc)
         begin
            case (paddr)
               `DCSC_OFS_BPCOND: bp_cond_q <= pwdata;
               `DCSC_OFS_BPMASK: bp_mask_q <= pwdata;
               `DCSC_OFS_BPACT:
               begin
                  bp_act_q   <= pwdata[1:0];
                  pass_cnt_q <= pwdata[15:8];
               end
               `DCSC_OFS_OVLORG: ovl_origin_q <= ovl_round(pwdata[15:0], ovl_size_2k);
               `DCSC_OFS_ROMPTR: rom_ptr_q <= pwdata[ROM_AW-1:0];
               default:          rom_ptr_q <= rom_ptr_q;
            endcase
         end
         // Sticky refusal flag; a refusal in the clearing write still wins
         if (acc && pslverr_q)
            err_q <= 1'b1;
         else if (wr_acc && is_cmd && pwdata[31])
            err_q <= 1'b0;
         // Breakpoint action while the target runs
         if (tgt_cyc_valid && bp_enable_q && hit && (state_q == S_DISP || state_q == S_RT))
         begin
            if (bp_act_q == `DCSC_ACT_COUNT && pass_cnt_q != 8'h00)
               pass_cnt_q <= pass_cnt_q - 8'h01;
            else
            begin
               state_q    <= S_HALT;
               tgt_halt_q <= 1'b1;
               steal_ok_q <= 1'b0;
            end
         end
         // Loss of control overrides the breakpoint action, keys and launch; only a reset (sys_rst or console reset) overrides it
         if (tgt_lost && state_q != S_ERR)
         begin
            state_q    <= S_ERR;
            sys_err_q  <= 1'b1;
            steal_ok_q <= 1'b0;
         end
         else if (cmd_go)
         begin
            case (key)
               `DCSC_K_HALT:
               begin
                  state_q    <= S_HALT;
                  tgt_halt_q <= 1'b1;
                  steal_ok_q <= 1'b0;
               end
               `DCSC_K_RUNDISP:
               begin
                  state_q    <= S_DISP;
                  tgt_halt_q <= 1'b0;
                  steal_ok_q <= 1'b1;
               end
               `DCSC_K_RUNRT:
               begin
                  state_q    <= S_RT;
                  tgt_halt_q <= 1'b0;
                  steal_ok_q <= 1'b0;
               end
               `DCSC_K_BPEN:   bp_enable_q  <= 1'b1;
               `DCSC_K_BPDIS:  bp_enable_q  <= 1'b0;
               `DCSC_K_TRALL:  trace_mode_q <= `DCSC_TR_ALL;
               `DCSC_K_TRBP:   trace_mode_q <= `DCSC_TR_BP;
               `DCSC_K_TROFF:  trace_mode_q <= `DCSC_TR_OFF;
               `DCSC_K_TRDISP:
               begin
                  trace_mode_q <= `DCSC_TR_OFF;
                  tr_dptr_q    <= tr_last;
               end
               `DCSC_K_TRNEXT: tr_dptr_q <= tr_dptr_q + {{(TRACE_AW-1){1'b0}}, 1'b1};
               `DCSC_K_TRPREV: tr_dptr_q <= tr_dptr_q - {{(TRACE_AW-1){1'b0}}, 1'b1};
               `DCSC_K_CPURST:
               begin
                  rst_cnt_q   <= RST_CYC8;
                  tgt_reset_q <= 1'b1;
               end
               `DCSC_K_SUBR:
               begin
                  subr_q       <= pwdata[7:4];
                  subr_armed_q <= 1'b1;
               end
               `DCSC_K_FINISH:
               begin
                  // Finish only starts a launch from halt with a choice armed
                  if (state_q == S_HALT && subr_armed_q)
                  begin
                     state_q      <= S_LNCH;
                     subr_armed_q <= 1'b0;
                     lb_q         <= 4'h0;
                     lphase_q     <= 1'b0;
                     cfg0_q       <= 8'h00;
                  end
               end
               `DCSC_K_OVLEN:  ovl_enable_q <= 1'b1;
               `DCSC_K_OVLDIS: ovl_enable_q <= 1'b0;
               default:        ovl_enable_q <= ovl_enable_q;
            endcase
         end
         else if (state_q == S_LNCH)
         begin
            // Two cycles per byte: present the address, then take the byte
            if (!lphase_q)
            begin
               rom_addr_q <= lnch_addr(subr_q, lb_q);
               lphase_q   <= 1'b1;
            end
            else if (lb_q != 4'hF)
            begin
               lphase_q <= 1'b0;
               case (lb_q)
                  4'h0: tgt_pc_q[7:0]  <= rom_byte_q_src(rom_addr_q, rom_rdata);
                  4'h1: tgt_pc_q[15:8] <= rom_byte_q_src(rom_addr_q, rom_rdata);
                  4'h2: cfg0_q         <= rom_byte_q_src(rom_addr_q, rom_rdata);
                  4'h3: bp_cond_q[7:0]   <= rom_byte_q_src(rom_addr_q, rom_rdata);
                  4'h4: bp_cond_q[15:8]  <= rom_byte_q_src(rom_addr_q, rom_rdata);
                  4'h5: bp_cond_q[23:16] <= rom_byte_q_src(rom_addr_q, rom_rdata);
                  4'h6: bp_cond_q[31:24] <= rom_byte_q_src(rom_addr_q, rom_rdata);
                  4'h7: bp_mask_q[7:0]   <= rom_byte_q_src(rom_addr_q, rom_rdata);
                  4'h8: bp_mask_q[15:8]  <= rom_byte_q_src(rom_addr_q, rom_rdata);
                  4'h9: bp_mask_q[23:16] <= rom_byte_q_src(rom_addr_q, rom_rdata);
                  4'hA: bp_mask_q[31:24] <= rom_byte_q_src(rom_addr_q, rom_rdata);
                  4'hB: bp_act_q         <= lnch_byte[1:0];
                  4'hC: ovl_origin_q[7:0] <= rom_byte_q_src(rom_addr_q, rom_rdata);
                  default: ovl_origin_q[15:8] <= rom_byte_q_src(rom_addr_q, rom_rdata);
               endcase
               // Subroutines 8-F stop after the vector
               if (lb_q == 4'h1 && subr_q >= `DCSC_CFG_SUBRS)
                  lb_q <= 4'hF;
               else if (lb_q == `DCSC_LAST_BYTE)
               begin
                  lb_q         <= 4'hF;
                  trace_mode_q <= {cfg0_q[`DCSC_CF_TRHI], cfg0_q[`DCSC_CF_TRLO]};
                  bp_enable_q  <= cfg0_q[`DCSC_CF_BPEN];
                  ovl_enable_q <= cfg0_q[`DCSC_CF_OVLEN];
                  if (cfg0_q[`DCSC_CF_RST])
                  begin
                     rst_cnt_q   <= RST_CYC8;
                     tgt_reset_q <= 1'b1;
                  end
               end
               else
                  lb_q <= lb_q + 4'h1;
            end
            else if (rst_cnt_q == 8'h00)
            begin
               // Reset from the config block finishes before the jump
               ovl_origin_q      <= ovl_round(ovl_origin_q, ovl_size_2k);
               tgt_pc_load_q     <= 1'b1;
               tgt_int_disable_q <= 1'b1;
               state_q           <= S_DISP;
               tgt_halt_q        <= 1'b0;
               steal_ok_q        <= 1'b1;
               lphase_q          <= 1'b0;
            end
         end
      end
   end

   // Byte source for the launch: shadow RAM below 0080, ROM above
   function [7:0] rom_byte_q_src;
      input [ROM_AW-1:0] a;
      input [7:0]        r;
      begin
         rom_byte_q_src = (a < `DCSC_SHADOW_TOP) ? shadow_mem[a[6:0]] : r;
      end
   endfunction
endmodule

// ===== verif/dcsc_monitor.sv
// Checker of the debug console control ports
`timescale 1ns/1ps
module dcsc_monitor (
   input logic ref_clk,
   input logic sys_rst,
   input logic console_reset_key,
   input logic psel,
   input logic penable,
   input logic tgt_lost,
   input logic pready_q,
   input logic tgt_reset_q,
   input logic tgt_halt_q,
   input logic steal_ok_q,
   input logic sys_err_q,
   input logic tgt_pc_load_q,
   input logic tgt_int_disable_q
);
   // Single domain; either reset key silences checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst || console_reset_key);
   sequence s_setup; psel && !penable; endsequence
   sequence s_release; $fell(sys_rst); endsequence
   // Bus answers in the first access cycle, for one cycle only
   property p_zero_wait; s_setup |=> pready_q ##1 !pready_q; endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("bus answer late or long");
   property p_rst_hold; s_release |-> tgt_reset_q [*8]; endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("target reset dropped early");
   // Pulse ends after its timer, never hangs
   property p_rst_end; s_release |-> ##[90:110] !tgt_reset_q; endproperty
   a_rst_end: assert property (p_rst_end) else $error("target reset stuck");
   property p_lost; tgt_lost |=> sys_err_q; endproperty
   a_lost: assert property (p_lost) else $error("lost control not flagged");
   property p_err_hold; sys_err_q |=> sys_err_q; endproperty
   a_err_hold: assert property (p_err_hold) else $error("system error left early");
   property p_launch; tgt_pc_load_q |-> tgt_int_disable_q ##1 !tgt_pc_load_q; endproperty
   a_launch: assert property (p_launch) else $error("launch without interrupt disable");
   property p_launch_run; tgt_pc_load_q |-> ##[0:1] steal_ok_q; endproperty
   a_launch_run: assert property (p_launch_run) else $error("launch not in display run");
   property p_halt_excl; !sys_err_q && tgt_halt_q |-> !steal_ok_q; endproperty
   a_halt_excl: assert property (p_halt_excl) else $error("stealing while halted");
endmodule

// ===== verif/dcsc_tgt_model.sv
// Target CPU bus and front panel ROM model
`timescale 1ns/1ps
module dcsc_tgt_model (
   input  logic        ref_clk,
   input  logic [10:0] rom_addr_q,
   output logic        tgt_cyc_valid = 1'b0,
   output logic [15:0] tgt_addr = 16'h0000,
   output logic [7:0]  tgt_data = 8'h00,
   output logic [7:0]  tgt_stat = 8'h00,
   output logic [7:0]  tgt_pins,
   output logic [7:0]  rom_rdata
);
   // Pattern ROM; pins fixed so the status view is checkable
   assign rom_rdata = rom_addr_q[7:0] ^ 8'h5A;
   assign tgt_pins = 8'h3C;
   // One machine cycle; bus shows inverted junk afterwards, not stale data
   task cyc(input logic [15:0] a, input logic [7:0] d, input logic [7:0] s);
      tgt_cyc_valid <= 1'b1;
      tgt_addr <= a;
      tgt_data <= d;
      tgt_stat <= s;
      @(posedge ref_clk);
      tgt_cyc_valid <= 1'b0;
      tgt_addr <= ~a;
      tgt_data <= ~d;
      tgt_stat <= ~s;
      @(posedge ref_clk);
   endtask
endmodule

// ===== verif/tb.sv
// Bench for the debug console control block
`timescale 1ns/1ps
`include "dcsc_defines.vh"
module tb;
   logic        ref_clk = 1'b0, sys_rst = 1'b1, console_reset_key = 1'b0, tgt_lost = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ovl_size_2k = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   wire  [31:0] prdata_q;
   wire  [15:0] tgt_addr, tgt_pc_q, ovl_origin_q;
   wire  [10:0] rom_addr_q;
   wire  [7:0]  tgt_data, tgt_stat, tgt_pins, rom_rdata;
   wire         pready_q, pslverr_q, tgt_cyc_valid, tgt_reset_q, tgt_halt_q, steal_ok_q, sys_err_q;
   wire         tgt_pc_load_q, tgt_int_disable_q, bp_enable_q, ovl_enable_q;
   int          fail_count = 0, compares = 0, n;
   dcsc_top u_dut (.ref_clk, .sys_rst, .console_reset_key, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata_q, .pready_q, .pslverr_q, .tgt_cyc_valid, .tgt_addr, .tgt_data, .tgt_stat, .tgt_pins, .tgt_lost,
      .ovl_size_2k, .rom_rdata, .rom_addr_q, .tgt_reset_q, .tgt_halt_q, .steal_ok_q, .sys_err_q, .tgt_pc_load_q,
      .tgt_pc_q, .tgt_int_disable_q, .bp_enable_q, .ovl_enable_q, .ovl_origin_q);
   dcsc_tgt_model u_tgt (.ref_clk, .rom_addr_q, .tgt_cyc_valid, .tgt_addr, .tgt_data, .tgt_stat, .tgt_pins,
      .rom_rdata);
   always #5 ref_clk = ~ref_clk;
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e)
      begin
         fail_count++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   // One transfer; released only after the answering edge
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee, input logic [31:0] m, e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do @(posedge ref_clk); while (pready_q !== 1'b1);
      chk("pready", 32'h1, {31'h0, pready_q});
      chk("pslverr", {31'h0, ee}, {31'h0, pslverr_q});
      if (!w) chk("rdata", e, prdata_q & m);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic ee); bus(1'b1, a, d, ee, 0, 0); endtask
   task rd(input logic [7:0] a, input logic [31:0] m, e); bus(1'b0, a, 0, 1'b0, m, e); endtask
   task key(input logic [7:0] k, input logic ee); wr(`DCSC_OFS_CMD, {24'h0, k}, ee); endtask
   // Waits for the launch pulse; a miss shows in the checks after it
   task wait_pc;
      n = 0;
      while (tgt_pc_load_q !== 1'b1 && n < 300)
      begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   task test_done;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Hang guard, far beyond the expected run
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      test_done();
   end
   initial
   begin
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd(`DCSC_OFS_STATUS, 32'h11F, 32'h101);
      repeat (110) @(posedge ref_clk);
      rd(`DCSC_OFS_STATUS, 32'h100, 32'h0);
      wr(`DCSC_OFS_OVLORG, 32'h1234, 1'b0);
      rd(`DCSC_OFS_OVLORG, 32'hFFFF, 32'h1000);
      ovl_size_2k <= 1'b1;
      wr(`DCSC_OFS_OVLORG, 32'h1FFF, 1'b0);
      rd(`DCSC_OFS_OVLORG, 32'hFFFF, 32'h1800);
      wr(`DCSC_OFS_BPCOND, 32'h12345678, 1'b0);
      wr(`DCSC_OFS_BPMASK, 32'hFFFF0000, 1'b0);
      $display("test halt setup done");
      key(8'h02, 1'b0);
      for (int i = 2; i < 6; i++) wr(8'(i * 4), 32'hFFFFFFFF, 1'b1);
      rd(`DCSC_OFS_BPCOND, 32'hFFFFFFFF, 32'h12345678);
      key(8'h0B, 1'b1);
      rd(`DCSC_OFS_STATUS, 32'h401F, 32'h4004);
      key(8'h0A, 1'b0);
      rd(`DCSC_OFS_STATUS, 32'h100, 32'h100);
      repeat (110) @(posedge ref_clk);
      key(8'h01, 1'b0);
      chk("steal", 32'h1, {31'h0, steal_ok_q});
      chk("halt", 32'h0, {31'h0, tgt_halt_q});
      key(8'h03, 1'b0);
      chk("bpen", 32'h1, {31'h0, bp_enable_q});
      u_tgt.cyc(16'h1235, 8'h99, 8'h00);
      rd(`DCSC_OFS_STATUS, 32'h1F, 32'h02);
      u_tgt.cyc(16'h1234, 8'h99, 8'h00);
      rd(`DCSC_OFS_STATUS, 32'h1F, 32'h01);
      chk("halt", 32'h1, {31'h0, tgt_halt_q});
      $display("test real time done");
      wr(`DCSC_OFS_SHADOW, 32'h02EF, 1'b0);
      wr(`DCSC_OFS_SHADOW, 32'h03BE, 1'b0);
      wr(`DCSC_OFS_SHADOW, 32'h2C02, 1'b0);
      for (int i = 'h2D; i < 'h38; i++) wr(`DCSC_OFS_SHADOW, (i << 8) | i, 1'b0);
      key(8'h1B, 1'b0);
      rd(`DCSC_OFS_BPACT, 32'hF0000, 32'h10000);
      key(8'h0C, 1'b0);
      wait_pc();
      chk("pc", 32'hBEEF, {16'h0, tgt_pc_q});
      chk("intdis", 32'h1, {31'h0, tgt_int_disable_q});
      rd(`DCSC_OFS_STATUS, 32'h341F, 32'h1002);
      rd(`DCSC_OFS_BPCOND, 32'hFFFFFFFF, 32'h302F2E2D);
      rd(`DCSC_OFS_BPACT, 32'h3, 32'h1);
      chk("ovlorg", 32'h3000, {16'h0, ovl_origin_q});
      wr(`DCSC_OFS_ROMPTR, 32'h123, 1'b0);
      @(posedge ref_clk);
      rd(`DCSC_OFS_ROMDATA, 32'hFF, 32'h79);
      wr(`DCSC_OFS_ROMPTR, 32'h002, 1'b0);
      @(posedge ref_clk);
      rd(`DCSC_OFS_ROMDATA, 32'hFF, 32'hEF);
      key(8'h0D, 1'b0);
      chk("ovlen", 32'h1, {31'h0, ovl_enable_q});
      for (int i = 0; i < 3; i++) u_tgt.cyc(16'h0100 + 16'(i), 8'(i), 8'h33);
      key(8'h07, 1'b0);
      rd(`DCSC_OFS_TRACE, 32'hFFFFFFFF, 32'h01020233);
      key(8'h09, 1'b0);
      rd(`DCSC_OFS_TRACE, 32'hFFFFFFFF, 32'h01010133);
      $display("test launch and trace done");
      tgt_lost <= 1'b1;
      @(posedge ref_clk);
      tgt_lost <= 1'b0;
      @(posedge ref_clk);
      key(8'h03, 1'b1);
      key(8'h04, 1'b0);
      chk("bpen", 32'h0, {31'h0, bp_enable_q});
      key(8'h05, 1'b0);
      key(8'h07, 1'b0);
      rd(`DCSC_OFS_STATUS, 32'hFF001F, 32'h3C0008);
      console_reset_key <= 1'b1;
      repeat (2) @(posedge ref_clk);
      console_reset_key <= 1'b0;
      rd(`DCSC_OFS_STATUS, 32'h7F1F, 32'h0101);
      rd(`DCSC_OFS_BPCOND, 32'hFFFFFFFF, 32'h0);
      chk("ovlorg", 32'h0, {16'h0, ovl_origin_q});
      key(8'h0C, 1'b1);
      wr(`DCSC_OFS_SHADOW, 32'h1234, 1'b0);
      wr(`DCSC_OFS_SHADOW, 32'h1356, 1'b0);
      key(8'h9B, 1'b0);
      key(8'h0C, 1'b0);
      wait_pc();
      chk("pc", 32'h5634, {16'h0, tgt_pc_q});
      chk("intdis", 32'h1, {31'h0, tgt_int_disable_q});
      rd(`DCSC_OFS_BPCOND, 32'hFFFFFFFF, 32'h0);
      rd(`DCSC_OFS_STATUS, 32'h301F, 32'h0002);
      $display("test error and console reset done");
      test_done();
   end
endmodule
bind dcsc_top dcsc_monitor u_mon (.ref_clk, .sys_rst, .console_reset_key, .psel, .penable, .tgt_lost, .pready_q,
   .tgt_reset_q, .tgt_halt_q, .steal_ok_q, .sys_err_q, .tgt_pc_load_q, .tgt_int_disable_q);
